/* File: hdl/mb_pkg.sv */
// Shared constants, carrier types and the check-code step for the handler.
package mb_pkg;
  // Function codes that the handler serves.
  localparam logic [7:0]  FN_READ     = 8'h03;  // Read holding registers.
  localparam logic [7:0]  FN_WR_ONE   = 8'h06;  // Preset single register.
  localparam logic [7:0]  FN_DIAG     = 8'h08;  // Loopback diagnostics.
  localparam logic [7:0]  FN_WR_MANY  = 8'h10;  // Preset multiple registers.
  localparam logic [7:0]  EXC_FLAG    = 8'h80;  // Added to a failing function.
  // Error codes carried by an exception response.
  localparam logic [7:0]  EX_FUNC     = 8'h01;  // Unsupported function.
  localparam logic [7:0]  EX_ADDR     = 8'h02;  // Address out of range.
  localparam logic [7:0]  EX_QTY      = 8'h03;  // Quantity or shape wrong.
  localparam logic [7:0]  EX_DIAG     = 8'h04;  // Self-diagnostic fault.
  // Check code preset and reflected polynomial.
  localparam logic [15:0] CRC_INIT    = 16'hFFFF;
  localparam logic [15:0] CRC_POLY    = 16'hA001;
  // Quantity limits per query.
  localparam logic [15:0] RD_MAX      = 16'h007D;  // 125 registers.
  localparam logic [15:0] WR_MAX      = 16'h007B;  // 123 registers.
  // Frame shape figures, in bytes.
  localparam logic [8:0]  LEN_FIXED   = 9'h008;  // Length of 03/06/08 queries.
  localparam logic [8:0]  LEN_WR_HDR  = 9'h009;  // 10H length less its data.
  localparam logic [8:0]  LEN_MIN     = 9'h004;  // Shortest frame worth checking.
  localparam logic [8:0]  LEN_MAX     = 9'h0FF;  // Longest frame kept.
  localparam logic [8:0]  PL_ECHO     = 9'h006;  // Echo body before check code.
  localparam logic [8:0]  PL_EXC      = 9'h003;  // Exception body length.
  localparam logic [8:0]  RD_HDR      = 9'h003;  // Read reply bytes before data.
  localparam logic [7:0]  WR_DATA_POS = 8'h07;   // First data byte of a 10H query.
  // Silent gap, in bit times, that closes a frame.
  localparam logic [4:0]  GAP_BITS    = 5'h18;

  // One byte on a stream with its qualifier.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_strm_t;

  // Handler sequence.
  typedef enum {S_RX, S_CHECK, S_WR_HI, S_WR_LO, S_TX_LOAD, S_TX_FETCH,
                S_TX_WAIT} state_t;

  // Kind of response being built.
  typedef enum {M_ECHO, M_EXC, M_READ} resp_t;

  // Folds one byte into the check code, least significant bit first.
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte
endpackage : mb_pkg

/* File: hdl/word_store.sv */
// Single-port memory with a registered read, used for frames and registers.
module word_store #(
  parameter int WIDTH = 16,  // Bits per word.
  parameter int DEPTH = 256, // Number of words.
  parameter int AW    = 8    // Address bits.
) (
  input  wire logic             i_clk,
  input  wire logic             i_we,
  input  wire logic [AW-1:0]    i_addr,
  input  wire logic [WIDTH-1:0] i_wdata,
  output logic      [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage array; no reset, contents persist.

  // Write takes effect at the edge; read data appear one edge after the address.
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule : word_store

/* File: hdl/modbus_rtu_slave_handler.sv */
// Slave message handler: frames queries, checks them, answers them.
// What this block does
// - Read query carries address, count, high first.
// - Read reply: count doubled, registers high-first ascending.
// - Single write carries register number and value.
// - Register values travel high byte first.
// - Single write answered by exact echo.
// - Diagnostics query echoed unchanged.
// - Multiple write: 1-123 registers, byte count doubled.
// - Multiple write reply: address, function, start, count.
// - Exception: function plus 80H, one error code.
// - Frame ends in FFFFH/A001 check code.
// - 24 silent bit times close a frame.
module modbus_rtu_slave_handler #(
  parameter int NUM_REGS = 256, // Holding registers present.
  parameter int RW_FIRST = 16   // First writable register; below is read-only.
) (
  input  wire logic               i_clk,
  input  wire logic               i_srst,
  input  wire logic [7:0]         i_slave_addr, // This slave's address.
  input  wire logic               i_diag_fault, // Self-diagnostic error seen.
  input  wire logic               i_bit_tick,   // One pulse per bit time.
  input  wire mb_pkg::byte_strm_t i_rx,         // Received bytes.
  input  wire logic               i_rx_error,   // Character error on a byte.
  input  wire logic               i_tx_ready,   // Transmitter takes the byte.
  output mb_pkg::byte_strm_t      o_tx          // Response bytes.
);
  import mb_pkg::*;

  localparam int RAW = $clog2(NUM_REGS); // Register address bits.

  state_t          st, next_st;           // Sequence state.
  resp_t           mode, next_mode;       // Response kind.
  logic [8:0]      len, next_len;         // Bytes received in this frame.
  logic            active, next_active;   // A frame has started.
  logic            bad, next_bad;         // Character error or overflow.
  logic [4:0]      gap, next_gap;         // Silent bit times since last byte.
  logic [15:0]     crc, next_crc;         // Running receive check code.
  logic [0:7][7:0] hdr, next_hdr;         // First eight query bytes.
  logic [7:0]      exc, next_exc;         // Exception code to send.
  logic [8:0]      idx, next_idx;         // Response byte index.
  logic [8:0]      pl, next_pl;           // Response length before check code.
  logic [15:0]     tcrc, next_tcrc;       // Running transmit check code.
  logic [7:0]      ptr, next_ptr;         // Frame buffer read pointer.
  logic [15:0]     cur, next_cur;         // Register being written.
  logic [15:0]     cnt, next_cnt;         // Registers left to write.
  logic [7:0]      whi, next_whi;         // Upper byte of the word in flight.
  byte_strm_t      tx, next_tx;           // Output byte register.

  logic            buf_we;                // Frame buffer write strobe.
  logic [7:0]      buf_addr;              // Frame buffer address.
  logic [7:0]      buf_rdata;             // Frame buffer read data.
  logic            reg_we;                // Register store write strobe.
  logic [RAW-1:0]  reg_addr;              // Register store address.
  logic [15:0]     reg_wdata;             // Register store write data.
  logic [15:0]     reg_rdata;             // Register store read data.

  // Decoded query fields, all sent high byte first.
  logic [7:0]  f_fn;                      // Function byte.
  logic [15:0] f_a;                       // Start, register or test code.
  logic [15:0] f_q;                       // Count or value.
  logic [7:0]  f_bc;                      // Byte count of a 10H query.
  logic [16:0] f_end;                     // One past the last register.
  assign f_fn  = hdr[1];
  assign f_a   = {hdr[2], hdr[3]};
  assign f_q   = {hdr[4], hdr[5]};
  assign f_bc  = hdr[6];
  assign f_end = {1'b0, f_a} + {1'b0, f_q};

  // The whole query is kept so that a multiple write can be applied only
  // after its check code has proved good.
  word_store #(.WIDTH(8), .DEPTH(256), .AW(8)) u_frame (
    .i_clk   (i_clk),
    .i_we    (buf_we),
    .i_addr  (buf_addr),
    .i_wdata (i_rx.data),
    .o_rdata (buf_rdata)
  );

  // Holding registers reached by the read and write functions.
  word_store #(.WIDTH(16), .DEPTH(NUM_REGS), .AW(RAW)) u_regs (
    .i_clk   (i_clk),
    .i_we    (reg_we),
    .i_addr  (reg_addr),
    .i_wdata (reg_wdata),
    .o_rdata (reg_rdata)
  );

  // Next-state logic for framing, checking, writing and transmitting.
  always_comb begin
    logic [7:0] b;
    b           = 8'h00;
    next_st     = st;
    next_mode   = mode;
    next_len    = len;
    next_active = active;
    next_bad    = bad;
    next_gap    = gap;
    next_crc    = crc;
    next_hdr    = hdr;
    next_exc    = exc;
    next_idx    = idx;
    next_pl     = pl;
    next_tcrc   = tcrc;
    next_ptr    = ptr;
    next_cur    = cur;
    next_cnt    = cnt;
    next_whi    = whi;
    next_tx     = tx;
    buf_we      = 1'b0;
    buf_addr    = len[7:0];
    reg_we      = 1'b0;
    reg_addr    = cur[RAW-1:0];
    reg_wdata   = {whi, buf_rdata};
    case (st)
      // Collect bytes until the line stays silent long enough.
      S_RX: begin
        if (i_rx.valid) begin
          next_active = 1'b1;
          next_gap    = 5'h00;
          if (len == LEN_MAX) begin
            next_bad = 1'b1;  // Too long: drop the frame at its end.
          end else begin
            buf_we   = 1'b1;
            next_len = len + 9'h001;
            next_crc = crc_byte(crc, i_rx.data);
            if (len < LEN_FIXED) begin
              next_hdr[len[2:0]] = i_rx.data;
            end
          end
          if (i_rx_error) begin
            next_bad = 1'b1;
          end
        end else if (active && i_bit_tick) begin
          next_gap = gap + 5'h01;
          if (gap == GAP_BITS - 5'h01) begin
            next_st = S_CHECK;
          end
        end
      end
      // Judge the finished frame and choose the answer.
      S_CHECK: begin
        next_st    = S_TX_LOAD;
        next_idx   = 9'h000;
        next_tcrc  = CRC_INIT;
        next_mode  = M_ECHO;
        next_pl    = PL_ECHO;
        next_exc   = 8'h00;
        // Check code residue is zero only over an intact frame.
        if (bad || len < LEN_MIN || crc != 16'h0000 ||
            hdr[0] != i_slave_addr) begin
          next_st = S_RX;
        end else if (i_diag_fault) begin
          next_exc = EX_DIAG;
        end else begin
          case (f_fn)
            FN_READ: begin
              if (len != LEN_FIXED || f_q == 16'h0000 || f_q > RD_MAX) begin
                next_exc = EX_QTY;
              end else if (f_end > 17'(NUM_REGS)) begin
                next_exc = EX_ADDR;
              end else begin
                next_mode = M_READ;
                next_pl   = RD_HDR + {f_q[7:0], 1'b0};
              end
            end
            FN_WR_ONE: begin
              if (len != LEN_FIXED) begin
                next_exc = EX_QTY;
              end else if (f_a < 16'(RW_FIRST) ||
                           f_a >= 16'(NUM_REGS)) begin
                next_exc = EX_ADDR;
              end else begin
                reg_we    = 1'b1;
                reg_addr  = f_a[RAW-1:0];
                reg_wdata = f_q;
              end
            end
            FN_DIAG: begin
              // A nonzero test code is not a supported test.
              if (len != LEN_FIXED || f_a != 16'h0000) begin
                next_exc = EX_QTY;
              end
            end
            FN_WR_MANY: begin
              if (f_q == 16'h0000 || f_q > WR_MAX ||
                  f_bc != {f_q[6:0], 1'b0} ||
                  len != LEN_WR_HDR + {1'b0, f_bc}) begin
                next_exc = EX_QTY;
              end else if (f_a < 16'(RW_FIRST) ||
                           f_end > 17'(NUM_REGS)) begin
                next_exc = EX_ADDR;
              end else begin
                next_st  = S_WR_HI;
                buf_addr = WR_DATA_POS;
                next_ptr = WR_DATA_POS + 8'h01;
                next_cur = f_a;
                next_cnt = f_q;
              end
            end
            default: begin
              next_exc = EX_FUNC;
            end
          endcase
        end
        if (next_exc != 8'h00) begin
          next_mode = M_EXC;
          next_pl   = PL_EXC;
          next_st   = S_TX_LOAD;
          reg_we    = 1'b0;
        end
        next_len    = 9'h000;
        next_active = 1'b0;
        next_bad    = 1'b0;
        next_gap    = 5'h00;
        next_crc    = CRC_INIT;
      end
      // Upper byte of a register value arrives from the frame buffer.
      S_WR_HI: begin
        next_whi = buf_rdata;
        buf_addr = ptr;
        next_ptr = ptr + 8'h01;
        next_st  = S_WR_LO;
      end
      // Lower byte arrives; store the word and move on.
      S_WR_LO: begin
        reg_we   = 1'b1;
        buf_addr = ptr;
        next_ptr = ptr + 8'h01;
        next_cur = cur + 16'h0001;
        next_cnt = cnt - 16'h0001;
        next_st  = (cnt == 16'h0001) ? S_TX_LOAD : S_WR_HI;
      end
      // Pick the next response byte, or fetch register data for it.
      S_TX_LOAD: begin
        if (idx < pl) begin
          case (mode)
            M_EXC: begin
              b = (idx == 9'h000) ? hdr[0] :
                  (idx == 9'h001) ? (hdr[1] + EXC_FLAG) : exc;
            end
            M_READ: begin
              b = (idx == 9'h000) ? hdr[0] :
                  (idx == 9'h001) ? hdr[1] : {f_q[6:0], 1'b0};
            end
            default: begin
              b = hdr[idx[2:0]];
            end
          endcase
          if (mode == M_READ && idx >= RD_HDR) begin
            // Word index is half the data byte offset, ascending.
            reg_addr = RAW'(f_a + {7'h00, (idx - RD_HDR) >> 1});
            next_st  = S_TX_FETCH;
          end else begin
            next_tx   = '{valid: 1'b1, data: b};
            next_tcrc = crc_byte(tcrc, b);
            next_st   = S_TX_WAIT;
          end
        end else if (idx == pl) begin
          next_tx = '{valid: 1'b1, data: tcrc[7:0]};
          next_st = S_TX_WAIT;
        end else if (idx == pl + 9'h001) begin
          next_tx = '{valid: 1'b1, data: tcrc[15:8]};
          next_st = S_TX_WAIT;
        end else begin
          next_st = S_RX;
        end
      end
      // Register data are ready; odd index sends the upper byte first.
      S_TX_FETCH: begin
        b         = idx[0] ? reg_rdata[15:8] : reg_rdata[7:0];
        next_tx   = '{valid: 1'b1, data: b};
        next_tcrc = crc_byte(tcrc, b);
        next_st   = S_TX_WAIT;
      end
      // Hold the byte until the transmitter takes it.
      S_TX_WAIT: begin
        if (i_tx_ready) begin
          next_tx.valid = 1'b0;
          next_idx      = idx + 9'h001;
          next_st       = S_TX_LOAD;
        end
      end
      default: begin
        next_st = S_RX;
      end
    endcase
  end

  // State register; bytes arriving while an answer is in progress are
  // ignored, since the master waits for the answer anyway.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st     <= S_RX;
      mode   <= M_ECHO;
      len    <= 9'h000;
      active <= 1'b0;
      bad    <= 1'b0;
      gap    <= 5'h00;
      crc    <= CRC_INIT;
      hdr    <= '0;
      exc    <= 8'h00;
      idx    <= 9'h000;
      pl     <= 9'h000;
      tcrc   <= CRC_INIT;
      ptr    <= 8'h00;
      cur    <= 16'h0000;
      cnt    <= 16'h0000;
      whi    <= 8'h00;
      tx     <= '0;
    end else begin
      st     <= next_st;
      mode   <= next_mode;
      len    <= next_len;
      active <= next_active;
      bad    <= next_bad;
      gap    <= next_gap;
      crc    <= next_crc;
      hdr    <= next_hdr;
      exc    <= next_exc;
      idx    <= next_idx;
      pl     <= next_pl;
      tcrc   <= next_tcrc;
      ptr    <= next_ptr;
      cur    <= next_cur;
      cnt    <= next_cnt;
      whi    <= next_whi;
      tx     <= next_tx;
    end
  end

  assign o_tx = tx;
endmodule : modbus_rtu_slave_handler

/* File: verif/modbus_rtu_slave_handler_chk.sv */
// Port-level checker for the slave message handler.
module handler_chk (
  input wire logic               i_clk,
  input wire logic               i_srst,
  input wire logic [7:0]         i_slave_addr,
  input wire logic               i_diag_fault,
  input wire logic               i_bit_tick,
  input wire mb_pkg::byte_strm_t i_rx,
  input wire logic               i_rx_error,
  input wire logic               i_tx_ready,
  input wire mb_pkg::byte_strm_t o_tx
);
  timeunit 1ns;
  timeprecision 1ns;
  import mb_pkg::*;
  logic [4:0] gap;    // Ticks since the last query byte, saturating.
  logic [8:0] rx_idx; // Bytes seen in the current query.
  logic [7:0] rx_fn;  // Function byte of the current query.
  logic [8:0] tx_idx; // Reply bytes taken since the last query byte.
  // Saturation keeps a long idle time from wrapping back below the gap.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      gap <= 5'h00;
      rx_idx <= 9'h000;
      rx_fn <= 8'h00;
      tx_idx <= 9'h000;
    end else if (i_rx.valid) begin
      gap <= 5'h00;
      rx_idx <= (gap >= GAP_BITS) ? 9'h001 : rx_idx + 9'h001;
      if (gap < GAP_BITS && rx_idx == 9'h001) begin
        rx_fn <= i_rx.data;
      end
      tx_idx <= 9'h000;
    end else begin
      if (i_bit_tick && gap != 5'h1F) begin
        gap <= gap + 5'h01;
      end
      if (o_tx.valid && i_tx_ready) begin
        tx_idx <= tx_idx + 9'h001;
      end
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // An accepted function byte with the failure flag set.
  sequence s_exc_fn;
    o_tx.valid && i_tx_ready && tx_idx == 9'h001 && o_tx.data[7];
  endsequence
  // One idle cycle, then an error code from the known set.
  sequence s_code;
    !o_tx.valid ##1 (o_tx.valid && o_tx.data inside {[EX_FUNC:EX_DIAG]});
  endsequence
  a_reset_idle: assert property (disable iff (1'b0)
    i_srst |=> !o_tx.valid && o_tx.data == 8'h00)
    else $error("reply stream not idle after reset");
  a_tx_hold: assert property (o_tx.valid && !i_tx_ready |=>
    o_tx.valid && $stable(o_tx.data))
    else $error("reply byte changed before it was taken");
  a_tx_drop: assert property (o_tx.valid && i_tx_ready |=> !o_tx.valid)
    else $error("reply valid stayed up after acceptance");
  a_gap_quiet: assert property (o_tx.valid |-> gap >= GAP_BITS)
    else $error("reply started before the frame gap");
  a_addr_echo: assert property (o_tx.valid && tx_idx == 9'h000 |->
    o_tx.data == i_slave_addr)
    else $error("reply does not start with the slave address");
  a_func_echo: assert property (o_tx.valid && tx_idx == 9'h001 |->
    o_tx.data == rx_fn || o_tx.data == (rx_fn | EXC_FLAG))
    else $error("reply function byte wrong");
  a_exc_code: assert property (s_exc_fn |=> s_code)
    else $error("exception code missing or out of set");
  a_diag_code: assert property (i_diag_fault && o_tx.valid &&
    tx_idx == 9'h002 |-> o_tx.data == EX_DIAG)
    else $error("fault reply lacks the diagnostic code");
endmodule : handler_chk

bind modbus_rtu_slave_handler handler_chk handler_chk_i (
  .i_clk(i_clk), .i_srst(i_srst), .i_slave_addr(i_slave_addr),
  .i_diag_fault(i_diag_fault), .i_bit_tick(i_bit_tick), .i_rx(i_rx),
  .i_rx_error(i_rx_error), .i_tx_ready(i_tx_ready), .o_tx(o_tx));

/* File: verif/mb_master.sv */
// Bus master model: sends queries with check codes, collects replies.
module mb_master (
  input  wire logic               i_clk,
  input  wire mb_pkg::byte_strm_t i_tx,     // Reply bytes.
  input  wire logic               i_slow,   // Stall replies when high.
  output mb_pkg::byte_strm_t      o_rx,     // Query bytes.
  output logic                    o_rx_err, // Character error flag.
  output logic                    o_tick,   // Bit time pulse.
  output logic                    o_ready   // Reply byte taken.
);
  timeunit 1ns;
  timeprecision 1ns;
  import mb_pkg::*;
  int         cyc = 0; // Cycle count behind ticks and stalls.
  logic [7:0] rsp[$];  // Reply bytes taken so far.
  initial begin
    o_rx = '0;
    o_rx_err = 1'b0;
    o_tick = 1'b0;
    o_ready = 1'b0;
  end
  // A tick every fourth cycle; a slow master is ready one cycle in three.
  always @(negedge i_clk) begin
    cyc <= cyc + 1;
    o_tick <= (cyc % 4) == 0;
    o_ready <= !i_slow || (cyc % 3) == 0;
  end
  // Reply bytes count only at an edge where valid meets ready.
  always @(posedge i_clk) begin
    if (i_tx.valid && o_ready) rsp.push_back(i_tx.data);
  end
  // Check code over a byte queue, least significant bit first.
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return c;
  endfunction : crc16
  // Sends a query; cut stretches one gap, err flags a byte (99: bad code).
  task automatic send(input logic [7:0] q[$], input int cut, input int err);
    logic [15:0] c;
    c = crc16(q) ^ ((err == 99) ? 16'h0001 : 16'h0000);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      repeat ((i == cut) ? 100 : 8) @(negedge i_clk);
      o_rx <= '{valid: 1'b1, data: q[i]};
      o_rx_err <= (i == err);
      @(negedge i_clk);
      // The released line shows the inverse, never the last byte.
      o_rx <= '{valid: 1'b0, data: ~q[i]};
      o_rx_err <= 1'b0;
    end
  endtask : send
endmodule : mb_master

/* File: verif/tb_top.sv */
// Self-checking bench: master model queries, replies against a model.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mb_pkg::*;
  typedef logic [7:0] bq_t[$];
  localparam logic [7:0] SL = 8'h11; // Address given to the slave.
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        fault = 1'b0;
  logic        slow = 1'b0;
  logic        tick, rx_err, ready;
  byte_strm_t  rx, tx;
  int unsigned failures = 0;
  int unsigned checks = 0;
  int          seed = 32'h5C876E6D;
  logic [15:0] mreg[256]; // Model of the holding registers.
  logic [15:0] rd_a[3] = '{16'h0030, 16'h0020, 16'h0023};
  logic [15:0] rd_n[3] = '{WR_MAX, 16'h0004, 16'h0001};
  always #50 clk = ~clk;
  modbus_rtu_slave_handler modbus_rtu_slave_handler_i (
    .i_clk(clk), .i_srst(srst), .i_slave_addr(SL), .i_diag_fault(fault),
    .i_bit_tick(tick), .i_rx(rx), .i_rx_error(rx_err),
    .i_tx_ready(ready), .o_tx(tx));
  mb_master mb_master_i (.i_clk(clk), .i_tx(tx), .i_slow(slow),
    .o_rx(rx), .o_rx_err(rx_err), .o_tick(tick), .o_ready(ready));
  // Six-byte query head: address, function, two words high first.
  function automatic bq_t fr(input logic [7:0] f, input logic [15:0] a, b);
    return {SL, f, a[15:8], a[7:0], b[15:8], b[7:0]};
  endfunction : fr
  function automatic bq_t ex(input logic [7:0] f, c);
    return {SL, f | EXC_FLAG, c};
  endfunction : ex
  task automatic cmp(input string w, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask : cmp
  // One query, then the whole reply; an empty e means no reply at all.
  task automatic run(input bq_t q, input bq_t e, input int cut, err);
    logic [15:0] c;
    int          n;
    c = mb_master_i.crc16(e);
    if (e.size() > 0) e = {e, c[7:0], c[15:8]};
    mb_master_i.rsp.delete();
    mb_master_i.send(q, cut, err);
    n = 0;
    while (mb_master_i.rsp.size() < e.size() && n < 4000) begin
      @(negedge clk);
      n++;
    end
    // Long enough for a stray reply and for the next frame gap.
    repeat (200) @(negedge clk);
    cmp("reply length", 16'(e.size()), 16'(mb_master_i.rsp.size()));
    foreach (e[i]) begin
      if (i < mb_master_i.rsp.size()) cmp("reply byte", e[i],
        mb_master_i.rsp[i]);
    end
  endtask : run
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  initial begin : watchdog
    repeat (60000) @(posedge clk);
    failures++;
    close_out();
  end
  initial begin : main
    logic [15:0] v, a;
    bq_t         q, e, none;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    // Single writes; odd ones meet a stalling master.
    for (int i = 0; i < 4; i++) begin
      a = 16'h0020 + 16'(i);
      v = 16'($random(seed));
      slow = i[0];
      mreg[a] = v;
      run(fr(FN_WR_ONE, a, v), fr(FN_WR_ONE, a, v), -1, -1);
    end
    // Longest write query: 123 registers, 255 bytes in all.
    q = {fr(FN_WR_MANY, 16'h0030, WR_MAX), 8'hF6};
    for (int i = 0; i < 123; i++) begin
      v = 16'($random(seed));
      mreg[48 + i] = v;
      q = {q, v[15:8], v[7:0]};
    end
    run(q, fr(FN_WR_MANY, 16'h0030, WR_MAX), -1, -1);
    // Refused shapes and codes, plus one good loopback; none of them may touch a register.
    run(fr(FN_READ, 16'h0020, 16'h0000), ex(FN_READ, EX_QTY), -1, -1);
    run(fr(FN_READ, 16'h0020, 16'h007E), ex(FN_READ, EX_QTY), -1, -1);
    q = {fr(FN_WR_MANY, 16'h0020, 16'h007C), 8'h02, 8'hAB, 8'hCD};
    run(q, ex(FN_WR_MANY, EX_QTY), -1, -1);
    v = 16'($random(seed));
    run(fr(FN_DIAG, 16'h0001, v), ex(FN_DIAG, EX_QTY), -1, -1);
    run(fr(FN_DIAG, 16'h0000, v), fr(FN_DIAG, 16'h0000, v), -1, -1);
    run(fr(8'h05, 16'h0020, 16'h0001), ex(8'h05, EX_FUNC), -1, -1);
    run(fr(FN_WR_ONE, 16'h0003, v), ex(FN_WR_ONE, EX_ADDR), -1, -1);
    // A read running past the last register, a block write into read-only.
    run(fr(FN_READ, 16'h00FF, 16'h0002), ex(FN_READ, EX_ADDR), -1, -1);
    q = {fr(FN_WR_MANY, 16'h000F, 16'h0001), 8'h02, 8'h12, 8'h34};
    run(q, ex(FN_WR_MANY, EX_ADDR), -1, -1);
    fault = 1'b1;
    run(fr(FN_READ, 16'h0020, 16'h0001), ex(FN_READ, EX_DIAG), -1, -1);
    fault = 1'b0;
    // Reads in ascending order, all of them under stalls.
    foreach (rd_a[k]) begin
      e = {SL, FN_READ, 8'(rd_n[k] * 2)};
      for (int i = 0; i < rd_n[k]; i++) begin
        e = {e, mreg[rd_a[k] + i][15:8], mreg[rd_a[k] + i][7:0]};
      end
      run(fr(FN_READ, rd_a[k], rd_n[k]), e, -1, -1);
    end
    // Silent drops: foreign address, bad code, character error, split.
    q = fr(FN_READ, 16'h0020, 16'h0001);
    q[0] = 8'h12;
    run(q, none, -1, -1);
    run(fr(FN_READ, 16'h0020, 16'h0001), none, -1, 99);
    run(fr(FN_READ, 16'h0020, 16'h0001), none, -1, 2);
    run(fr(FN_READ, 16'h0020, 16'h0001), none, 3, -1);
    // Reset in mid-run: the handler must come back idle and answer again.
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    run(fr(FN_DIAG, 16'h0000, v), fr(FN_DIAG, 16'h0000, v), -1, -1);
    close_out();
  end
endmodule : tb_top
